// File: hw/usart_cfg_pkg.sv
// constants and register layout of the serial controller command and mode block

package usart_cfg_pkg;
	// ----------------------------------------------------------------
	// register offsets (byte addresses)
	// ----------------------------------------------------------------
	localparam logic [7:0] OFS_CTRL = 8'h00;
	localparam logic [7:0] OFS_MODE = 8'h04;
	localparam logic [7:0] OFS_STAT = 8'h14;
	localparam logic [7:0] OFS_WPMR = 8'he4;
	localparam logic [7:0] OFS_WPSR = 8'he8;
	localparam logic [31:0] MODE_RST = 32'h0000_0000;
	// ----------------------------------------------------------------
	// command register bits
	// ----------------------------------------------------------------
	localparam int CB_RX_RST = 2;
	localparam int CB_TX_RST = 3;
	localparam int CB_RX_EN = 4;
	localparam int CB_RX_DIS = 5;
	localparam int CB_TX_EN = 6;
	localparam int CB_TX_DIS = 7;
	localparam int CB_STA_CLR = 8;
	localparam int CB_REPEAT_LIMIT_REACHED_FLAG_CLR = 13;
	localparam int CB_CS_FORCE = 18;
	localparam int CB_CS_REL = 19;
	// ----------------------------------------------------------------
	// mode register fields
	// ----------------------------------------------------------------
	localparam int MF_MODE = 0;
	localparam int MF_CLKS = 4;
	localparam int MF_CHAR_LENGTH_FIELD = 6;
	localparam int MF_SYNC = 8;
	localparam int MF_PAR = 9;
	localparam int MF_STOP = 12;
	localparam int MF_CHANNEL_LOOP_SELECT = 14;
	localparam int MF_BIT_ORDER = 16;
	localparam int MF_NINE = 17;
	localparam int MF_CLOCK_OUTPUT_ENABLE = 18;
	localparam int MF_OVER = 19;
	localparam int MF_NACK_INHIBIT = 20;
	localparam int MF_SUCCESSIVE_NACK_LIMIT = 21;
	localparam int MF_INV = 22;
	localparam int MF_VSYNC = 23;
	localparam int MF_MAXIT = 24;
	localparam int MF_FILTER = 28;
	localparam int MF_MAN = 29;
	localparam int MF_START_TRANSITION_POLARITY = 30;
	localparam int MF_DELIMITER_SELECT = 31;
	// ----------------------------------------------------------------
	// status bits and encodings
	// ----------------------------------------------------------------
	localparam int SB_OVR = 5;
	localparam int SB_UNR = 10;
	localparam int SB_REPEAT_LIMIT_REACHED_FLAG = 11;
	localparam int SB_RECEIVE_ENABLE_CMD = 16;
	localparam int SB_TRANSMIT_ENABLE_CMD = 17;
	localparam int SB_SS = 19;
	localparam int WP_SRC = 8;
	localparam logic [3:0] MODE_NORMAL = 4'h0;
	localparam logic [3:0] MODE_RS485 = 4'h1;
	localparam logic [3:0] MODE_HWHS = 4'h2;
	localparam logic [3:0] MODE_CARD0 = 4'h4;
	localparam logic [3:0] MODE_CARD1 = 4'h6;
	localparam logic [3:0] MODE_IRDA = 4'h8;
	localparam logic [3:0] MODE_LINM = 4'ha;
	localparam logic [3:0] MODE_LINS = 4'hb;
	localparam logic [3:0] MODE_SPIM = 4'he;
	localparam logic [3:0] MODE_SPIS = 4'hf;
	localparam logic [1:0] CLKS_RSVD = 2'h2;
	localparam logic [1:0] CLKS_DIV = 2'h1;
	localparam logic [1:0] CLKS_EXT = 2'h3;
	localparam logic [2:0] CLK_DIV_LAST = 3'h7;
	localparam logic [2:0] PAR_RSVD_A = 3'h5;
	localparam logic [2:0] PAR_RSVD_B = 3'h7;
	localparam logic [1:0] STOP_ONE_HALF = 2'h1;
	localparam logic [1:0] STOP_RSVD = 2'h3;
	localparam logic [1:0] LOOP_ECHO = 2'h1;
	localparam logic [1:0] LOOP_LOCAL = 2'h2;
	localparam logic [1:0] LOOP_REMOTE = 2'h3;
	localparam logic [3:0] CHAR_BASE = 4'h5;
	localparam logic [3:0] CHAR_NINE = 4'h9;
	localparam logic [4:0] OVS_16 = 5'h10;
	localparam logic [4:0] OVS_8 = 5'h08;
endpackage : usart_cfg_pkg

// File: hw/usart_control_and_mode_config.sv
// command, mode and protection registers of the serial controller with line-side helpers
`timescale 1ns/10ps

module usart_control_and_mode_config
	import usart_cfg_pkg::*;
(
	input wire logic core_clk,
	input wire logic rst_n,
	input wire logic [7:0] address,
	input wire logic read,
	input wire logic write,
	input wire logic [31:0] writedata,
	output logic [31:0] readdata,
	output logic waitrequest,
	input wire logic rxd_pin,
	output logic txd_pin,
	input wire logic sck_in,
	output logic sck_out,
	output logic sck_oe,
	output logic rts_pin,
	input wire logic tx_bit,
	input wire logic tx_active,
	input wire logic baud_clk,
	input wire logic sample_tick,
	input wire logic [8:0] tx_data_in,
	input wire logic [8:0] rx_data_in,
	input wire logic thr_write,
	input wire logic thr_sync,
	input wire logic parity_error,
	input wire logic char_ok,
	input wire logic overrun_evt,
	input wire logic underrun_evt,
	output logic rx_bit,
	output logic [8:0] tx_data_out,
	output logic [8:0] rx_data_out,
	output logic clk_tick,
	output logic rx_reset,
	output logic tx_reset,
	output logic rx_enabled,
	output logic tx_enabled,
	output logic nack_send,
	output logic [3:0] op_mode,
	output logic [3:0] char_bits,
	output logic [2:0] parity_sel,
	output logic [1:0] stop_sel,
	output logic sync_mode,
	output logic msb_first,
	output logic [4:0] oversample,
	output logic line_code_en,
	output logic delimiter_one,
	output logic sync_field
);
	// ----------------------------------------------------------------
	// bus decode
	// ----------------------------------------------------------------
	logic wait_q;
	logic [31:0] rdata_q;
	logic [31:0] mode_q;
	logic write_lock_enable_q;
	logic write_violation_flag_q;
	logic [7:0] wpsrc_q;
	logic receive_enable_cmd_q;
	logic transmit_enable_cmd_q;
	logic ovr_q;
	logic unr_q;
	logic repeat_limit_reached_flag_q;
	logic ss_q;
	logic [31:0] rdata_d;
	wire req = read | write;
	wire take = req & ~wait_q;
	wire wr_take = write & take;
	wire rd_take = read & take;
	wire hit_ctrl = address == OFS_CTRL;
	wire hit_mode = address == OFS_MODE;
	wire hit_stat = address == OFS_STAT;
	wire hit_wpmr = address == OFS_WPMR;
	wire hit_wpsr = address == OFS_WPSR;
	wire cmd_wr = wr_take & hit_ctrl;
	wire [31:0] cmd = cmd_wr ? writedata : 32'h0000_0000;

	// one wait cycle per access keeps read data a registered answer
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			wait_q <= 1'b1;
			rdata_q <= 32'h0000_0000;
		end else begin
			wait_q <= ~(req & wait_q);
			rdata_q <= rdata_d;
		end
	end

	wire [31:0] stat_word = (32'(ovr_q) << SB_OVR) | (32'(unr_q) << SB_UNR)
		| (32'(repeat_limit_reached_flag_q) << SB_REPEAT_LIMIT_REACHED_FLAG) | (32'(receive_enable_cmd_q) << SB_RECEIVE_ENABLE_CMD)
		| (32'(transmit_enable_cmd_q) << SB_TRANSMIT_ENABLE_CMD) | (32'(ss_q) << SB_SS);
	wire [31:0] wpsr_word = (32'(wpsrc_q) << WP_SRC) | 32'(write_violation_flag_q);
	always_comb begin
		rdata_d = 32'h0000_0000;
		if (read & wait_q) begin
			if (hit_mode)
				rdata_d = mode_q;
			else if (hit_stat)
				rdata_d = stat_word;
			else if (hit_wpmr)
				rdata_d = 32'(write_lock_enable_q);
			else if (hit_wpsr)
				rdata_d = wpsr_word;
		end
	end

	// ----------------------------------------------------------------
	// mode register with write lock and encoding checks
	// ----------------------------------------------------------------
	wire [3:0] wd_mode = writedata[MF_MODE +: 4];
	wire [1:0] wd_clks = writedata[MF_CLKS +: 2];
	wire [2:0] wd_par = writedata[MF_PAR +: 3];
	wire [1:0] wd_stop = writedata[MF_STOP +: 2];
	wire wd_sync = writedata[MF_SYNC];
	wire mode_ok = wd_mode inside {MODE_NORMAL, MODE_RS485, MODE_HWHS, MODE_CARD0,
		MODE_CARD1, MODE_IRDA, MODE_LINM, MODE_LINS, MODE_SPIM, MODE_SPIS};
	wire clks_ok = wd_clks != CLKS_RSVD;
	wire par_ok = (wd_par != PAR_RSVD_A) && (wd_par != PAR_RSVD_B);
	wire stop_ok = (wd_stop != STOP_RSVD) && !(wd_stop == STOP_ONE_HALF && wd_sync);
	wire enc_ok = mode_ok & clks_ok & par_ok & stop_ok;
	wire mode_wr = wr_take & hit_mode;
	wire mode_load = mode_wr & ~write_lock_enable_q & enc_ok;
	wire violation = mode_wr & write_lock_enable_q;
	wire wpsr_rd = rd_take & hit_wpsr;

	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			mode_q <= MODE_RST;
			write_lock_enable_q <= 1'b0;
			write_violation_flag_q <= 1'b0;
			wpsrc_q <= 8'h00;
		end else begin
			if (mode_load)
				mode_q <= writedata;
			if (wr_take & hit_wpmr)
				write_lock_enable_q <= writedata[0];
			// a violation in the reading cycle survives the clear
			write_violation_flag_q <= violation | (write_violation_flag_q & ~wpsr_rd);
			if (violation)
				wpsrc_q <= address;
		end
	end

	// ----------------------------------------------------------------
	// mode fields
	// ----------------------------------------------------------------
	wire [3:0] f_mode = mode_q[MF_MODE +: 4];
	wire [1:0] f_clks = mode_q[MF_CLKS +: 2];
	wire [1:0] f_char_length_field = mode_q[MF_CHAR_LENGTH_FIELD +: 2];
	wire [1:0] f_loop = mode_q[MF_CHANNEL_LOOP_SELECT +: 2];
	wire [2:0] f_maxit = mode_q[MF_MAXIT +: 3];
	wire f_inv = mode_q[MF_INV];
	wire f_filter = mode_q[MF_FILTER];
	wire is_spi = (f_mode == MODE_SPIM) | (f_mode == MODE_SPIS);
	wire is_spim = f_mode == MODE_SPIM;
	wire is_card = (f_mode == MODE_CARD0) | (f_mode == MODE_CARD1);
	wire [3:0] bits_d = mode_q[MF_NINE] ? CHAR_NINE : CHAR_BASE + 4'(f_char_length_field);

	// ----------------------------------------------------------------
	// command register
	// ----------------------------------------------------------------
	wire rx_on = cmd[CB_RX_EN] & ~cmd[CB_RX_DIS];
	wire tx_on = cmd[CB_TX_EN] & ~cmd[CB_TX_DIS];
	wire sta_clr = cmd[CB_STA_CLR] & is_spi;
	// force wins if both are written together; select also falls while sending
	wire ss_d = (is_spim & cmd[CB_CS_FORCE]) ? 1'b0 :
		(is_spim & cmd[CB_CS_REL]) ? 1'b1 : ss_q;

	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			receive_enable_cmd_q <= 1'b0;
			transmit_enable_cmd_q <= 1'b0;
			rx_reset <= 1'b0;
			tx_reset <= 1'b0;
			ovr_q <= 1'b0;
			unr_q <= 1'b0;
			ss_q <= 1'b1;
			rts_pin <= 1'b1;
		end else begin
			rx_reset <= cmd[CB_RX_RST];
			tx_reset <= cmd[CB_TX_RST];
			if (cmd[CB_RX_DIS] | cmd[CB_RX_RST])
				receive_enable_cmd_q <= 1'b0;
			else if (rx_on)
				receive_enable_cmd_q <= 1'b1;
			if (cmd[CB_TX_DIS] | cmd[CB_TX_RST])
				transmit_enable_cmd_q <= 1'b0;
			else if (tx_on)
				transmit_enable_cmd_q <= 1'b1;
			ovr_q <= overrun_evt | (ovr_q & ~sta_clr);
			unr_q <= underrun_evt | (unr_q & ~sta_clr);
			ss_q <= ss_d;
			rts_pin <= is_spim ? (ss_d & ~tx_active) : 1'b1;
		end
	end

	// ----------------------------------------------------------------
	// smart card nack and repeat limit
	// ----------------------------------------------------------------
	logic [2:0] err_cnt_q;
	wire card_err = is_card & parity_error & ~mode_q[MF_NACK_INHIBIT];
	wire under_lim = err_cnt_q < f_maxit;
	wire lim_hit = card_err & mode_q[MF_SUCCESSIVE_NACK_LIMIT] & ~under_lim;
	wire repeat_limit_reached_flag_clr = cmd[CB_REPEAT_LIMIT_REACHED_FLAG_CLR] & is_card;

	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			err_cnt_q <= 3'h0;
			nack_send <= 1'b0;
			repeat_limit_reached_flag_q <= 1'b0;
		end else begin
			nack_send <= card_err & (~mode_q[MF_SUCCESSIVE_NACK_LIMIT] | under_lim);
			if (char_ok | cmd[CB_RX_RST])
				err_cnt_q <= 3'h0;
			else if (card_err & mode_q[MF_SUCCESSIVE_NACK_LIMIT] & under_lim)
				err_cnt_q <= err_cnt_q + 3'h1;
			repeat_limit_reached_flag_q <= lim_hit | (repeat_limit_reached_flag_q & ~repeat_limit_reached_flag_clr);
		end
	end

	// ----------------------------------------------------------------
	// line side: synchronisers, filter, loop routing
	// ----------------------------------------------------------------
	logic rxd_s1_q;
	logic rxd_s2_q;
	logic sck_s1_q;
	logic sck_s2_q;
	logic sck_d_q;
	logic [2:0] rx_win_q;
	logic [2:0] div_q;
	wire rx_vote = (rx_win_q[0] & rx_win_q[1]) | (rx_win_q[0] & rx_win_q[2])
		| (rx_win_q[1] & rx_win_q[2]);
	wire rx_line = f_filter ? rx_vote : rxd_s2_q;
	wire rx_route = (f_loop == LOOP_LOCAL) ? tx_bit :
		(f_loop == LOOP_REMOTE) ? 1'b1 : rx_line;
	wire tx_route = (f_loop == LOOP_LOCAL) ? 1'b1 :
		(f_loop == LOOP_ECHO || f_loop == LOOP_REMOTE) ? rx_line : tx_bit;
	wire tick_d = (f_clks == CLKS_EXT) ? (sck_s2_q & ~sck_d_q) :
		(f_clks == CLKS_DIV) ? (div_q == CLK_DIV_LAST) : 1'b1;

	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			rxd_s1_q <= 1'b1;
			rxd_s2_q <= 1'b1;
			sck_s1_q <= 1'b0;
			sck_s2_q <= 1'b0;
			sck_d_q <= 1'b0;
			rx_win_q <= 3'h7;
			div_q <= 3'h0;
			rx_bit <= 1'b1;
			txd_pin <= 1'b1;
			clk_tick <= 1'b0;
			sck_out <= 1'b0;
			sck_oe <= 1'b0;
		end else begin
			rxd_s1_q <= rxd_pin;
			rxd_s2_q <= rxd_s1_q;
			sck_s1_q <= sck_in;
			sck_s2_q <= sck_s1_q;
			sck_d_q <= sck_s2_q;
			if (sample_tick)
				rx_win_q <= {rx_win_q[1:0], rxd_s2_q};
			div_q <= div_q + 3'h1;
			rx_bit <= rx_route;
			txd_pin <= tx_route;
			clk_tick <= tick_d;
			sck_out <= baud_clk;
			sck_oe <= mode_q[MF_CLOCK_OUTPUT_ENABLE] & (f_clks != CLKS_EXT);
		end
	end

	// ----------------------------------------------------------------
	// data polarity, framing and character settings
	// ----------------------------------------------------------------
	wire [8:0] inv_mask = {9{f_inv}};
	wire sync_d = (mode_q[MF_VSYNC] & thr_write) ? thr_sync :
		mode_q[MF_VSYNC] ? sync_field : mode_q[MF_START_TRANSITION_POLARITY];

	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			tx_data_out <= 9'h000;
			rx_data_out <= 9'h000;
			op_mode <= MODE_NORMAL;
			char_bits <= CHAR_BASE;
			parity_sel <= 3'h0;
			stop_sel <= 2'h0;
			sync_mode <= 1'b0;
			msb_first <= 1'b0;
			oversample <= OVS_16;
			line_code_en <= 1'b0;
			delimiter_one <= 1'b0;
			sync_field <= 1'b0;
		end else begin
			tx_data_out <= tx_data_in ^ inv_mask;
			rx_data_out <= rx_data_in ^ inv_mask;
			op_mode <= f_mode;
			char_bits <= bits_d;
			parity_sel <= mode_q[MF_PAR +: 3];
			stop_sel <= mode_q[MF_STOP +: 2];
			sync_mode <= mode_q[MF_SYNC];
			msb_first <= mode_q[MF_BIT_ORDER];
			oversample <= mode_q[MF_OVER] ? OVS_8 : OVS_16;
			line_code_en <= mode_q[MF_MAN];
			delimiter_one <= mode_q[MF_DELIMITER_SELECT];
			sync_field <= sync_d;
		end
	end

	// ----------------------------------------------------------------
	// outputs
	// ----------------------------------------------------------------
	assign readdata = rdata_q;
	assign waitrequest = wait_q;
	assign rx_enabled = receive_enable_cmd_q;
	assign tx_enabled = transmit_enable_cmd_q;

endmodule : usart_control_and_mode_config

// File: testbench/usart_cfg_chk.sv
// port checker for the command and mode block
`timescale 1ns/10ps
module usart_cfg_chk
	import usart_cfg_pkg::*;
(
	input wire logic core_clk,
	input wire logic rst_n,
	input wire logic [7:0] address,
	input wire logic write,
	input wire logic [31:0] writedata,
	input wire logic waitrequest,
	input wire logic rts_pin,
	input wire logic tx_active,
	input wire logic rx_reset,
	input wire logic tx_reset,
	input wire logic rx_enabled,
	input wire logic tx_enabled,
	input wire logic nack_send,
	input wire logic parity_error,
	input wire logic [1:0] stop_sel,
	input wire logic sync_mode,
	input wire logic [3:0] op_mode,
	input wire logic [4:0] oversample
);
	// ----------------------------------------
	// decoded bus events
	// ----------------------------------------
	wire ctl_wr = write && !waitrequest && address == OFS_CTRL;
	wire rx_rst_w = ctl_wr && writedata[CB_RX_RST];
	wire tx_rst_w = ctl_wr && writedata[CB_TX_RST];
	wire spim = op_mode == MODE_SPIM;
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!rst_n);
	a_wait_single: assert property ($fell(waitrequest) |=> waitrequest)
		else $error("wait low too long");
	a_wait_answer: assert property ($rose(write) |=> !waitrequest)
		else $error("no answer to write");
	a_rx_reset_cmd: assert property (rx_rst_w |-> ##[1:2] rx_reset)
		else $error("receiver reset missing");
	a_tx_reset_only: assert property (tx_reset |-> $past(tx_rst_w) || $past(tx_rst_w, 2))
		else $error("transmitter reset without command");
	a_tx_enable: assert property (ctl_wr && writedata[CB_TX_EN] && !writedata[CB_TX_DIS]
		&& !writedata[CB_TX_RST] |-> ##2 tx_enabled) else $error("transmitter not enabled");
	a_rx_disable: assert property (ctl_wr && (writedata[CB_RX_DIS] || writedata[CB_RX_RST])
		|-> ##2 !rx_enabled) else $error("receiver not disabled");
	a_force_low: assert property (ctl_wr && spim && writedata[CB_CS_FORCE] |-> ##2 !rts_pin)
		else $error("select not forced");
	a_release_high: assert property ((ctl_wr && spim && writedata[CB_CS_REL]
		&& !writedata[CB_CS_FORCE] && !tx_active) ##1 !tx_active[*2] |-> rts_pin)
		else $error("select not released");
	a_ovs_legal: assert property (oversample == OVS_16 || oversample == OVS_8)
		else $error("bad oversampling");
	a_stop_legal: assert property (stop_sel != STOP_RSVD && !(sync_mode && stop_sel == STOP_ONE_HALF))
		else $error("reserved stop setting");
	a_nack_cause: assert property (nack_send |-> $past(parity_error) || $past(parity_error, 2))
		else $error("nack without parity error");
endmodule : usart_cfg_chk

// File: testbench/usart_control_and_mode_config_bench.sv
// self-checking bench for the command and mode block
`timescale 1ns/10ps
module usart_control_and_mode_config_bench;
	import usart_cfg_pkg::*;
	logic core_clk = 0, rst_n = 0, read = 0, write = 0, tx_bit = 0, tx_active = 0, baud_clk = 0;
	logic sample_tick = 0, thr_write = 0, thr_sync = 0, parity_error = 0, char_ok = 0;
	logic overrun_evt = 0, underrun_evt = 0, frame_en = 0, rxd_pin, sck_in, txd_pin, sck_out;
	logic sck_oe, rts_pin, rx_bit, clk_tick, rx_reset, tx_reset, rx_enabled, tx_enabled, nack_send;
	logic sync_mode, msb_first, line_code_en, delimiter_one, sync_field;
	logic [7:0] address = 0;
	logic [31:0] writedata = 0, readdata, rd, v, mode_m = MODE_RST;
	logic [8:0] tx_data_in = 0, rx_data_in = 0, tx_data_out, rx_data_out;
	logic [3:0] op_mode, char_bits;
	logic [2:0] parity_sel;
	logic [1:0] stop_sel;
	logic [4:0] oversample;
	logic waitrequest, rxe_m = 0, txe_m = 0, cs_m = 1;
	logic [3:0] modes [11] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h6, 4'h8, 4'ha, 4'hb, 4'he, 4'hf};
	int errors = 0, cmp_count = 0, cyc = 0, n;
	logic [3:0] rxh = 4'hf, sckh = 4'h0;
	logic [2:0] ewin = 3'h7, dcnt = 3'h0;
	logic exp_rx = 1, exp_tx = 1, exp_tick = 0, exp_sck = 0;
	wire [1:0] elp = mode_m[MF_CHANNEL_LOOP_SELECT +: 2];
	wire [1:0] eclk = mode_m[MF_CLKS +: 2];
	wire evote = (ewin[0] & ewin[1]) | (ewin[0] & ewin[2]) | (ewin[1] & ewin[2]);
	wire eline = mode_m[MF_FILTER] ? evote : rxh[1];
	usart_control_and_mode_config u_usart_control_and_mode_config (.core_clk, .rst_n, .address,
		.read, .write, .writedata, .readdata, .waitrequest, .rxd_pin, .txd_pin, .sck_in, .sck_out,
		.sck_oe, .rts_pin, .tx_bit, .tx_active, .baud_clk, .sample_tick, .tx_data_in, .rx_data_in,
		.thr_write, .thr_sync, .parity_error, .char_ok, .overrun_evt, .underrun_evt, .rx_bit,
		.tx_data_out, .rx_data_out, .clk_tick, .rx_reset, .tx_reset, .rx_enabled, .tx_enabled,
		.nack_send, .op_mode, .char_bits, .parity_sel, .stop_sel, .sync_mode, .msb_first,
		.oversample, .line_code_en, .delimiter_one, .sync_field);
	usart_peer u_usart_peer (.core_clk, .frame_en, .rxd_pin, .sck_in);
	always #5 core_clk = ~core_clk;
	// ----------------------------------------
	// free-running line stimulus and hang guard
	// ----------------------------------------
	always @(posedge core_clk) begin
		cyc <= cyc + 1;
		baud_clk <= ~baud_clk;
		sample_tick <= cyc[3:0] == 4'h0;
		tx_bit <= 1'($urandom);
		char_ok <= 1'($urandom);
		if (cyc == 8000) begin
			errors++;
			end_sim();
		end
	end
	// ----------------------------------------
	// cycle model of line routing and clock selection
	// ----------------------------------------
	// pin history mirrors the two-flop synchroniser delay
	always @(posedge core_clk) begin
		rxh <= {rxh[2:0], rxd_pin};
		sckh <= {sckh[2:0], sck_in};
		if (sample_tick) ewin <= {ewin[1:0], rxh[1]};
		dcnt <= rst_n ? dcnt + 3'h1 : 3'h0;
		exp_sck <= baud_clk;
		exp_rx <= elp == LOOP_LOCAL ? tx_bit : elp == LOOP_REMOTE ? 1'b1 : eline;
		exp_tx <= elp == LOOP_LOCAL ? 1'b1 : elp != 2'h0 ? eline : tx_bit;
		exp_tick <= eclk == CLKS_EXT ? sckh[1] & ~sckh[2] :
			eclk == CLKS_DIV ? dcnt == CLK_DIV_LAST : 1'b1;
	end
	task automatic end_sim();
		if (errors == 0 && cmp_count > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask : end_sim
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp) begin
			errors++;
			$display("[FAIL] %0t got %h exp %h", $time, got, exp);
		end
	endtask : chk
	task automatic tick(input int k);
		repeat (k) @(posedge core_clk);
		#1;
	endtask : tick
	// request held until waitrequest is seen low at an edge
	task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
		@(posedge core_clk);
		address <= a;
		writedata <= d;
		write <= wr;
		read <= !wr;
		do @(posedge core_clk); while (waitrequest !== 1'b0);
		rd = readdata;
		write <= 1'b0;
		read <= 1'b0;
	endtask : bus
	task automatic set_mode(input logic [31:0] m);
		bus(1, OFS_MODE, m);
		if (m[5:4] != CLKS_RSVD && m[11:9] != PAR_RSVD_A && m[11:9] != PAR_RSVD_B && m[3:0] != 4'h3
			&& m[13:12] != STOP_RSVD && !(m[13:12] == STOP_ONE_HALF && m[8])) mode_m = m;
	endtask : set_mode
	task automatic pulse_pe(output int k);
		k = 0;
		@(posedge core_clk);
		parity_error <= 1;
		@(posedge core_clk);
		parity_error <= 0;
		repeat (4) begin
			#1;
			k += nack_send;
			@(posedge core_clk);
		end
	endtask : pulse_pe
	initial begin
		void'($urandom(32'h5148));
		repeat (20) @(posedge core_clk);
		rst_n <= 1;
		tick(1);
		chk({rts_pin, char_bits, oversample}, {1'b1, CHAR_BASE, OVS_16});
		frame_en <= 1;
		for (int i = 0; i < 40; i++) begin
			v = $urandom;
			v[3:0] = modes[$urandom_range(10)];
			v[27] = 0;
			if (!v[21]) v[26:24] = 3'h0;
			tx_data_in <= 9'($urandom);
			rx_data_in <= 9'($urandom);
			set_mode(v);
			bus(0, OFS_MODE, 0);
			chk(rd, mode_m);
			tick(2);
			chk({op_mode, parity_sel, sync_mode, stop_sel}, {mode_m[3:0], mode_m[11:8], mode_m[13:12]});
			chk(char_bits, mode_m[17] ? CHAR_NINE : CHAR_BASE + mode_m[7:6]);
			chk({msb_first, oversample}, {mode_m[16], mode_m[19] ? OVS_8 : OVS_16});
			chk({line_code_en, delimiter_one, sck_oe}, {mode_m[29], mode_m[31], mode_m[18] && mode_m[5:4] != CLKS_EXT});
			chk({tx_data_out, rx_data_out}, {tx_data_in, rx_data_in} ^ {18{mode_m[22]}});
			if (!mode_m[23]) chk(sync_field, mode_m[30]);
		end
		frame_en <= 0;
		bus(1, OFS_WPMR, 32'h1);
		bus(1, OFS_MODE, 32'h0);
		bus(0, OFS_MODE, 0);
		chk(rd, mode_m);
		bus(0, OFS_WPSR, 0);
		chk({rd[15:8], rd[0]}, {OFS_MODE, 1'b1});
		bus(0, OFS_WPSR, 0);
		chk(rd[0], 1'b0);
		bus(1, OFS_WPMR, 32'h0);
		bus(1, 8'h40, 32'hffff_ffff);
		bus(0, 8'h40, 0);
		chk(rd, 32'h0);
		set_mode(32'h0000_0010);
		n = 0;
		tick(2);
		repeat (64) begin
			tick(1);
			n += clk_tick;
		end
		chk(n, 8);
		frame_en <= 1;
		for (int i = 0; i < 16; i++) begin
			v = 0;
			v[MF_CHANNEL_LOOP_SELECT +: 2] = i[1:0];
			v[MF_FILTER] = i[2];
			v[MF_CLKS +: 2] = {i[3], i[3] | i[0]};
			set_mode(v);
			tick(3);
			repeat (20) begin
				chk({rx_bit, txd_pin, clk_tick, sck_out}, {exp_rx, exp_tx, exp_tick, exp_sck});
				tick(1);
			end
		end
		frame_en <= 0;
		for (int i = 0; i < 2; i++) begin
			set_mode((32'h1 << MF_VSYNC) | (32'(!i[0]) << MF_START_TRANSITION_POLARITY));
			@(posedge core_clk);
			thr_write <= 1;
			thr_sync <= i[0];
			@(posedge core_clk);
			thr_write <= 0;
			tick(2);
			chk(sync_field, i[0]);
		end
		for (int i = 0; i < 3; i++) begin
			set_mode({10'h0, i == 2, i == 1, 16'h0, MODE_CARD0});
			tick(2);
			pulse_pe(n);
			chk(n, i == 0);
		end
		bus(0, OFS_STAT, 0);
		chk(rd[SB_REPEAT_LIMIT_REACHED_FLAG], 1'b1);
		bus(1, OFS_CTRL, 32'h1 << CB_REPEAT_LIMIT_REACHED_FLAG_CLR);
		bus(0, OFS_STAT, 0);
		chk(rd[SB_REPEAT_LIMIT_REACHED_FLAG], 1'b0);
		for (int i = 0; i < 2; i++) begin
			set_mode(i ? {28'h0, MODE_SPIM} : 32'h0);
			@(posedge core_clk);
			overrun_evt <= 1;
			underrun_evt <= 1;
			@(posedge core_clk);
			overrun_evt <= 0;
			underrun_evt <= 0;
			bus(1, OFS_CTRL, 32'h1 << CB_STA_CLR);
			bus(0, OFS_STAT, 0);
			chk({rd[SB_OVR], rd[SB_UNR]}, {2{!i[0]}});
		end
		for (int i = 0; i < 12; i++) begin
			v = $urandom & 32'h0000_00fc;
			bus(1, OFS_CTRL, v);
			if (v[CB_RX_RST] || v[CB_RX_DIS]) rxe_m = 0; else if (v[CB_RX_EN]) rxe_m = 1;
			if (v[CB_TX_RST] || v[CB_TX_DIS]) txe_m = 0; else if (v[CB_TX_EN]) txe_m = 1;
			tick(2);
			chk({rx_enabled, tx_enabled}, {rxe_m, txe_m});
			bus(0, OFS_STAT, 0);
			chk({rd[SB_RECEIVE_ENABLE_CMD], rd[SB_TRANSMIT_ENABLE_CMD]}, {rxe_m, txe_m});
		end
		for (int i = 0; i < 6; i++) begin
			v = 0;
			{v[CB_CS_REL], v[CB_CS_FORCE]} = 2'($urandom);
			bus(1, OFS_CTRL, v);
			if (v[CB_CS_FORCE]) cs_m = 0; else if (v[CB_CS_REL]) cs_m = 1;
			tick(2);
			chk(rts_pin, cs_m);
		end
		bus(1, OFS_CTRL, 32'h1 << CB_CS_REL);
		@(posedge core_clk);
		tx_active <= 1;
		tick(3);
		chk(rts_pin, 1'b0);
		end_sim();
	end
endmodule : usart_control_and_mode_config_bench
bind usart_control_and_mode_config usart_cfg_chk u_usart_cfg_chk (.core_clk, .rst_n, .address,
	.write, .writedata, .waitrequest, .rts_pin, .tx_active, .rx_reset, .tx_reset, .rx_enabled,
	.tx_enabled, .nack_send, .parity_error, .stop_sel, .sync_mode, .op_mode, .oversample);

// File: testbench/usart_peer.sv
// serial peer model on the receive line and external clock pin
`timescale 1ns/10ps
module usart_peer (
	input wire logic core_clk,
	input wire logic frame_en,
	output logic rxd_pin,
	output logic sck_in
);
	logic [3:0] cnt_q = 4'h0;
	initial rxd_pin = 1'b1;
	initial sck_in = 1'b0;
	// clock stands still and line idles high between frames
	always @(posedge core_clk) begin
		cnt_q <= cnt_q + 4'h1;
		sck_in <= frame_en & cnt_q[2];
		rxd_pin <= frame_en ? 1'($urandom) : 1'b1;
	end
endmodule : usart_peer
